// [ebp_port.sv]
// external memory port: bank decode, core/dma arbitration, async and sdram cycles
// assumes requesters hold their request until ack; registers over apb
//
// Notes on behaviour
// - four external banks, each set to async memory or sdram by software
// - async bank windows: 6M words in bank 0, 8M in banks 1-3
// - async decode ranges end at base plus 0x7fffff, bank 0 from 0x200000
// - sdram bank windows: 62M words in bank 0, 64M in banks 1-3
// - sdram decode ranges fill each 64M word bank slot, bank 0 from 0x200000
// - arbiter picks between competing core and dma requests
// - one select line per bank, four in total, any type mix
// - async timing held separately for every bank
// - partly populated windows are never remapped or joined together
// - sdram size per bank configurable from 4M to 256M bytes
// - sdram timing parameters programmable for slower parts
// - selectable external buffer timing for large sdram systems
// - bank ranges are 32-bit normal word addresses
// - simd access to sdram moves 64 bits, both element registers
// - compressed mode fetches 48-bit words holding up to three instructions
// - instruction fetch only from bank 0, both instruction modes
// - traditional fetch 0x200000-0x5fffff, compressed fetch 0x600000-0xffffff
`timescale 1ns/10ps
module ebp_port
   import ebp_pkg::*;
#(
   parameter int DATA_W = 64
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic core_req,
   input wire logic [31:0] core_addr,
   input wire logic core_write,
   input wire logic [DATA_W-1:0] core_wdata,
   input wire logic core_simd,
   input wire logic core_fetch,
   output logic core_ack,
   output logic core_err,
   output logic [DATA_W-1:0] core_rdata,
   input wire logic dma_req,
   input wire logic [31:0] dma_addr,
   input wire logic dma_write,
   input wire logic [DATA_W-1:0] dma_wdata,
   output logic dma_ack,
   output logic dma_err,
   output logic [DATA_W-1:0] dma_rdata,
   output logic [3:0] bank_select_lines_n,
   output logic [25:0] mem_addr,
   output logic [DATA_W-1:0] external_port_data_bus_out,
   output logic external_port_data_bus_oe,
   input wire logic [DATA_W-1:0] external_port_data_bus_in,
   output logic mem_rd_n,
   output logic mem_wr_n,
   output logic [2:0] sdram_cmd
);
   // ****************************************
   // functions
   // ****************************************
   // {hit, bank}; window top depends on the bank's type
   function automatic logic [2:0] ebp_decode(input logic [31:0] a, input logic [3:0] sd);
      logic [1:0] b;
      logic [25:0] top;
      logic hit;
      b = a[27:26];
      top = sd[b] ? EBP_SDRAM_TOP : EBP_ASYNC_TOP;
      hit = (a[31:28] == 4'h0) && (a[25:0] <= top);
      if (b == 2'h0 && a[25:0] < EBP_B0_LOW) begin
         hit = 1'b0;
      end
      ebp_decode = {hit, b};
   endfunction

   // populated sdram words for a size code: 1M words (4M bytes) doubled per step
   function automatic logic [26:0] ebp_words(input logic [2:0] code);
      logic [2:0] c;
      c = (code > EBP_SIZE_MAX) ? EBP_SIZE_MAX : code;
      ebp_words = {1'b0, EBP_SIZE_UNIT} << c;
   endfunction

   // ****************************************
   // registers
   // ****************************************
   logic [3:0] bank_mode;
   logic compressed_instruction_mode;
   logic [31:0] async_timing;
   logic [31:0] sdram_size;
   logic [3:0] cas_lat;
   logic [3:0] trcd;
   logic [3:0] trp;
   logic ext_buffer;
   ebp_state_t state;
   logic last_dma;
   logic [15:0] err_count;

   wire apb_setup = psel && !penable;
   wire apb_wr = psel && penable && pwrite;
   wire [7:0] reg_off = paddr[7:0];
   wire reg_hit = (paddr[31:8] == 24'h0) && (paddr[1:0] == 2'h0) && (reg_off <= EBP_REG_STATUS);
   wire [31:0] timing_word = {19'h0, ext_buffer, trp, trcd, cas_lat};
   wire [31:0] status_word = {err_count, 10'h0, last_dma, state != EBP_IDLE, 1'b0, state};

   assign pready = 1'b1;
   assign pslverr = psel && penable && !reg_hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_mode <= EBP_RST_BANK_MODE[3:0];
         compressed_instruction_mode <= EBP_RST_BANK_MODE[EBP_F_COMPRESSED];
         async_timing <= EBP_RST_ASYNC_TIMING;
         sdram_size <= EBP_RST_SDRAM_SIZE;
         cas_lat <= EBP_RST_SDRAM_TIMING[3:0];
         trcd <= EBP_RST_SDRAM_TIMING[7:4];
         trp <= EBP_RST_SDRAM_TIMING[11:8];
         ext_buffer <= EBP_RST_SDRAM_TIMING[EBP_F_EXT_BUFFER];
      end else if (apb_wr && reg_hit) begin
         case (reg_off)
            EBP_REG_BANK_MODE: begin
               bank_mode <= pwdata[3:0];
               compressed_instruction_mode <= pwdata[EBP_F_COMPRESSED];
            end
            EBP_REG_ASYNC_TIMING: begin
               async_timing <= pwdata;
            end
            EBP_REG_SDRAM_SIZE: begin
               sdram_size <= pwdata;
            end
            EBP_REG_SDRAM_TIMING: begin
               cas_lat <= pwdata[3:0];
               trcd <= pwdata[7:4];
               trp <= pwdata[11:8];
               ext_buffer <= pwdata[EBP_F_EXT_BUFFER];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (apb_setup) begin
         case (reg_off)
            EBP_REG_BANK_MODE: prdata <= {27'h0, compressed_instruction_mode, bank_mode};
            EBP_REG_ASYNC_TIMING: prdata <= async_timing;
            EBP_REG_SDRAM_SIZE: prdata <= sdram_size;
            EBP_REG_SDRAM_TIMING: prdata <= timing_word;
            EBP_REG_STATUS: prdata <= status_word;
            default: prdata <= 32'h0;
         endcase
         if (!reg_hit) begin
            prdata <= 32'h0;
         end
      end
   end

   // ****************************************
   // arbitration and request check
   // ****************************************
   // alternate on a tie so neither side starves
   wire pick_dma = dma_req && (!core_req || !last_dma);
   // no retake while an answer still stands
   wire pick_any = (core_req || dma_req) && (state == EBP_IDLE) && !core_ack && !dma_ack;
   wire [31:0] sel_addr = pick_dma ? dma_addr : core_addr;
   wire sel_write = pick_dma ? dma_write : core_write;
   wire [DATA_W-1:0] sel_wdata = pick_dma ? dma_wdata : core_wdata;
   wire sel_simd = !pick_dma && core_simd;
   wire sel_fetch = !pick_dma && core_fetch;
   wire [2:0] dec = ebp_decode(sel_addr, bank_mode);
   wire dec_hit = dec[2];
   wire [1:0] dec_bank = dec[1:0];
   wire dec_sd = bank_mode[dec_bank];
   wire [2:0] dec_size = sdram_size[dec_bank*EBP_SIZE_FIELD +: EBP_SIZE_FIELD];
   // no remap: a word past the populated part is refused, not folded in
   wire populated = !dec_sd || ({1'b0, sel_addr[25:0]} < ebp_words(dec_size));
   wire [25:0] fetch_low = compressed_instruction_mode ? EBP_COMP_LOW : EBP_TRAD_LOW;
   wire [25:0] fetch_top = compressed_instruction_mode ? EBP_COMP_TOP : EBP_TRAD_TOP;
   wire fetch_ok = (dec_bank == 2'h0) && (sel_addr[25:0] >= fetch_low) &&
                   (sel_addr[25:0] <= fetch_top) && !sel_write;
   wire req_ok = dec_hit && populated && (!sel_fetch || fetch_ok);
   wire [7:0] async_wait = async_timing[dec_bank*8 +: 8];

   // ****************************************
   // data input synchroniser
   // ****************************************
   logic [DATA_W-1:0] din_s1;
   logic [DATA_W-1:0] din_s2;
   logic [DATA_W-1:0] din_s3;
   logic [DATA_W-1:0] din_seen;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         din_s1 <= '0;
         din_s2 <= '0;
         din_s3 <= '0;
         din_seen <= '0;
      end else begin
         din_s1 <= external_port_data_bus_in;
         din_s2 <= din_s1;
         din_s3 <= din_s2;
         if (din_s2 == din_s3) begin
            din_seen <= din_s3;
         end
      end
   end
   wire [DATA_W-1:0] din_now = (din_s2 == din_s3) ? din_s3 : din_seen;

   // ****************************************
   // memory cycle sequencer
   // ****************************************
   logic cur_dma;
   logic cur_write;
   logic cur_wide;
   logic cur_fetch;
   logic cur_err;
   logic [1:0] cur_bank;
   logic [7:0] count;
   wire count_done = (count == 8'h0);
   wire [7:0] read_tail = cur_write ? 8'h0 : EBP_SYNC_LAT;
   wire [7:0] cas_wait = {4'h0, cas_lat} + {7'h0, ext_buffer} + read_tail;
   wire [3:0] sel_onehot = 4'h1 << cur_bank;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= EBP_IDLE;
         last_dma <= 1'b0;
         cur_dma <= 1'b0;
         cur_write <= 1'b0;
         cur_wide <= 1'b0;
         cur_fetch <= 1'b0;
         cur_err <= 1'b0;
         cur_bank <= 2'h0;
         count <= 8'h0;
         err_count <= 16'h0;
         mem_addr <= 26'h0;
         external_port_data_bus_out <= '0;
      end else begin
         if (!count_done) begin
            count <= count - 8'h1;
         end
         case (state)
            EBP_IDLE: begin
               if (pick_any) begin
                  last_dma <= pick_dma;
                  cur_dma <= pick_dma;
                  cur_write <= sel_write;
                  cur_wide <= sel_simd && dec_sd;
                  cur_fetch <= sel_fetch;
                  cur_bank <= dec_bank;
                  cur_err <= !req_ok;
                  mem_addr <= sel_addr[25:0];
                  external_port_data_bus_out <= sel_wdata;
                  if (!req_ok) begin
                     state <= EBP_DONE;
                     err_count <= err_count + 16'h1;
                  end else if (dec_sd) begin
                     state <= EBP_ACT;
                     count <= {4'h0, trcd};
                  end else begin
                     state <= EBP_ASYNC;
                     count <= async_wait + (sel_write ? 8'h0 : EBP_SYNC_LAT);
                  end
               end
            end
            EBP_ASYNC: begin
               if (count_done) begin
                  state <= EBP_DONE;
               end
            end
            EBP_ACT: begin
               if (count_done) begin
                  state <= EBP_ACCESS;
                  count <= cas_wait;
               end
            end
            EBP_ACCESS: begin
               if (count_done) begin
                  state <= EBP_PRE;
                  count <= {4'h0, trp};
               end
            end
            EBP_PRE: begin
               if (count_done) begin
                  state <= EBP_DONE;
               end
            end
            EBP_DONE: begin
               state <= EBP_IDLE;
            end
            default: begin
               state <= EBP_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // pin drive
   // ****************************************
   wire in_async = (state == EBP_ASYNC);
   wire in_sd = (state == EBP_ACT) || (state == EBP_ACCESS) || (state == EBP_PRE);
   wire access_first = (state == EBP_ACT) && count_done;
   wire pre_first = (state == EBP_ACCESS) && count_done;
   wire [2:0] next_cmd = access_first ? (cur_write ? EBP_CMD_WRITE : EBP_CMD_READ) :
                         pre_first ? EBP_CMD_PRE : EBP_CMD_NOP;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_select_lines_n <= 4'hf;
         mem_rd_n <= 1'b1;
         mem_wr_n <= 1'b1;
         external_port_data_bus_oe <= 1'b0;
         sdram_cmd <= EBP_CMD_NOP;
      end else begin
         bank_select_lines_n <= (in_async || in_sd) ? ~sel_onehot : 4'hf;
         mem_rd_n <= !(in_async && !cur_write);
         mem_wr_n <= !(in_async && cur_write);
         external_port_data_bus_oe <= (in_async || in_sd) && cur_write;
         if (state == EBP_IDLE && pick_any && req_ok && dec_sd) begin
            sdram_cmd <= EBP_CMD_ACT;
         end else begin
            sdram_cmd <= in_sd ? next_cmd : EBP_CMD_NOP;
         end
      end
   end

   // ****************************************
   // answers
   // ****************************************
   // normal words use the low 32 bits; fetches 48; sdram simd all 64
   wire [DATA_W-1:0] mask_n = {{(DATA_W-32){1'b0}}, 32'hffff_ffff};
   wire [DATA_W-1:0] mask_f = {{(DATA_W-48){1'b0}}, 48'hffff_ffff_ffff};
   wire [DATA_W-1:0] rmask = cur_wide ? {DATA_W{1'b1}} : (cur_fetch ? mask_f : mask_n);
   wire [DATA_W-1:0] next_rdata = (cur_err || cur_write) ? '0 : (din_now & rmask);
   wire done = (state == EBP_DONE);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_ack <= 1'b0;
         core_err <= 1'b0;
         core_rdata <= '0;
         dma_ack <= 1'b0;
         dma_err <= 1'b0;
         dma_rdata <= '0;
      end else begin
         core_ack <= done && !cur_dma;
         dma_ack <= done && cur_dma;
         core_err <= done && !cur_dma && cur_err;
         dma_err <= done && cur_dma && cur_err;
         if (done && !cur_dma) begin
            core_rdata <= next_rdata;
         end
         if (done && cur_dma) begin
            dma_rdata <= next_rdata;
         end
      end
   end
endmodule

// [ebp_pkg.sv]
// shared constants of the external memory port: register map, windows, commands
// assumes 32-bit word addresses from the core and dma side
package ebp_pkg;
   // ****************************************
   // register map (byte offsets)
   // ****************************************
   localparam logic [7:0] EBP_REG_BANK_MODE = 8'h00;
   localparam logic [7:0] EBP_REG_ASYNC_TIMING = 8'h04;
   localparam logic [7:0] EBP_REG_SDRAM_SIZE = 8'h08;
   localparam logic [7:0] EBP_REG_SDRAM_TIMING = 8'h0c;
   localparam logic [7:0] EBP_REG_STATUS = 8'h10;
   // reset values
   localparam logic [31:0] EBP_RST_BANK_MODE = 32'h0000_0000;
   localparam logic [31:0] EBP_RST_ASYNC_TIMING = 32'h0f0f_0f0f;
   localparam logic [31:0] EBP_RST_SDRAM_SIZE = 32'h0000_0000;
   localparam logic [31:0] EBP_RST_SDRAM_TIMING = 32'h0000_0333;
   // field positions
   localparam int EBP_F_COMPRESSED = 4;
   localparam int EBP_F_EXT_BUFFER = 12;
   localparam int EBP_SIZE_FIELD = 3;
   localparam logic [2:0] EBP_SIZE_MAX = 3'h6;
   // ****************************************
   // address windows (word addresses)
   // ****************************************
   localparam int EBP_BANKS = 4;
   localparam logic [25:0] EBP_B0_LOW = 26'h020_0000;
   localparam logic [25:0] EBP_ASYNC_TOP = 26'h07f_ffff;
   localparam logic [25:0] EBP_SDRAM_TOP = 26'h3ff_ffff;
   localparam logic [25:0] EBP_SIZE_UNIT = 26'h010_0000;
   localparam logic [25:0] EBP_TRAD_LOW = 26'h020_0000;
   localparam logic [25:0] EBP_TRAD_TOP = 26'h05f_ffff;
   localparam logic [25:0] EBP_COMP_LOW = 26'h060_0000;
   localparam logic [25:0] EBP_COMP_TOP = 26'h0ff_ffff;
   // timing
   localparam logic [7:0] EBP_SYNC_LAT = 8'h03;
   // sdram commands {ras_n, cas_n, we_n}
   localparam logic [2:0] EBP_CMD_NOP = 3'h7;
   localparam logic [2:0] EBP_CMD_ACT = 3'h3;
   localparam logic [2:0] EBP_CMD_READ = 3'h5;
   localparam logic [2:0] EBP_CMD_WRITE = 3'h4;
   localparam logic [2:0] EBP_CMD_PRE = 3'h2;
   typedef enum logic [2:0] {
      EBP_IDLE = 3'b000,
      EBP_ASYNC = 3'b001,
      EBP_ACT = 3'b010,
      EBP_ACCESS = 3'b011,
      EBP_PRE = 3'b100,
      EBP_DONE = 3'b101
   } ebp_state_t;
endpackage

// [ebp_port_chk.sv]
// checker of the external memory port outputs
// assumes it is bound into ebp_port and sees only its ports
`timescale 1ns/10ps
module ebp_port_chk
   import ebp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic core_ack,
   input wire logic core_err,
   input wire logic dma_ack,
   input wire logic dma_err,
   input wire logic [3:0] bank_select_lines_n,
   input wire logic [25:0] mem_addr,
   input wire logic mem_rd_n,
   input wire logic mem_wr_n,
   input wire logic [2:0] sdram_cmd
);
   // ****
   // output relations
   // ****
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sel_one_hot_a: assert property ($onehot0(~bank_select_lines_n))
      else $error("more than one bank select low");
   ack_pulse_a: assert property (core_ack |=> !core_ack)
      else $error("core ack longer than one cycle");
   ack_excl_a: assert property (!(core_ack && dma_ack))
      else $error("core and dma answered together");
   core_refuse_a: assert property (core_err |-> core_ack && $past(bank_select_lines_n, 2) == 4'hf)
      else $error("refused core request selected a bank");
   dma_refuse_a: assert property (dma_err |-> dma_ack && $past(bank_select_lines_n, 2) == 4'hf)
      else $error("refused dma request selected a bank");
   strobe_excl_a: assert property (!(!mem_rd_n && !mem_wr_n))
      else $error("read and write strobes low together");
   strobe_sel_a: assert property ((!mem_rd_n || !mem_wr_n) |-> bank_select_lines_n != 4'hf)
      else $error("async strobe without a bank select");
   async_window_a: assert property ((!mem_rd_n || !mem_wr_n) |-> mem_addr[25:23] == 3'h0)
      else $error("async cycle beyond the bank window");
   bank0_floor_a: assert property ((!mem_rd_n && !bank_select_lines_n[0]) |-> mem_addr >= EBP_B0_LOW)
      else $error("bank 0 async read below its window");
   sd_cmd_sel_a: assert property ((sdram_cmd != EBP_CMD_NOP && sdram_cmd != EBP_CMD_ACT) |-> bank_select_lines_n != 4'hf)
      else $error("sdram command without a bank select");
endmodule
bind ebp_port ebp_port_chk u_chk (.pclk(pclk), .presetn(presetn), .core_ack(core_ack),
   .core_err(core_err), .dma_ack(dma_ack), .dma_err(dma_err),
   .bank_select_lines_n(bank_select_lines_n), .mem_addr(mem_addr), .mem_rd_n(mem_rd_n),
   .mem_wr_n(mem_wr_n), .sdram_cmd(sdram_cmd));

// [ebp_mem_model.sv]
// behavioural model of the attached memory parts
// assumes the port's registered selects, strobes and sdram commands
// answers on the falling edge, like an untimed asynchronous part
`timescale 1ns/10ps
module ebp_mem_model
   import ebp_pkg::*;
(
   input wire logic pclk,
   input wire logic [3:0] bank_select_lines_n,
   input wire logic [25:0] mem_addr,
   input wire logic [63:0] external_port_data_bus_out,
   input wire logic external_port_data_bus_oe,
   input wire logic mem_wr_n,
   input wire logic [2:0] sdram_cmd,
   output logic [63:0] external_port_data_bus_in
);
   // ****
   // storage and read path
   // ****
   logic [63:0] mem [logic [27:0]]; // 64-bit wide parts only
   logic [1:0] bank;
   logic [27:0] key;
   assign bank = !bank_select_lines_n[3] ? 2'h3 : !bank_select_lines_n[2] ? 2'h2 :
      !bank_select_lines_n[1] ? 2'h1 : 2'h0;
   assign key = {bank, mem_addr}; // raw offset, no remap
   initial external_port_data_bus_in = 64'h0;
   always @(negedge pclk) begin
      if (bank_select_lines_n != 4'hf && external_port_data_bus_oe) begin
         if (!mem_wr_n || sdram_cmd == EBP_CMD_WRITE) begin
            mem[key] = external_port_data_bus_out;
         end
         external_port_data_bus_in <= ~external_port_data_bus_in;
      end else if (bank_select_lines_n != 4'hf) begin
         external_port_data_bus_in <= mem.exists(key) ? mem[key] : {36'h0, key};
      end else begin
         external_port_data_bus_in <= ~external_port_data_bus_in;
      end
   end
endmodule

// [ebp_port_bench.sv]
// self-checking bench of the external memory port
// assumes ebp_port, ebp_mem_model and the bound checker
`timescale 1ns/10ps
module ebp_port_bench;
   import ebp_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic core_req = 1'b0;
   logic [31:0] core_addr = 32'h0;
   logic core_write = 1'b0;
   logic [63:0] core_wdata = 64'h0;
   logic core_simd = 1'b0;
   logic core_fetch = 1'b0;
   logic dma_req = 1'b0;
   logic [31:0] dma_addr = 32'h0;
   logic dma_write = 1'b0;
   logic [63:0] dma_wdata = 64'h0;
   logic [31:0] prdata;
   logic pready, pslverr, core_ack, core_err, dma_ack, dma_err, oe, rd_n, wr_n, e, s;
   logic [63:0] core_rdata, dma_rdata, bus_out, bus_in, rd, rd2;
   logic e2, s2;
   logic [3:0] sel_n;
   logic [25:0] mem_addr;
   logic [2:0] cmd;
   logic [31:0] r32;
   int failures = 0;
   int n_compared = 0;
   int tm, t1, t2;
   initial forever #2 pclk = ~pclk;
   ebp_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .core_req(core_req), .core_addr(core_addr), .core_write(core_write),
      .core_wdata(core_wdata), .core_simd(core_simd), .core_fetch(core_fetch),
      .core_ack(core_ack), .core_err(core_err), .core_rdata(core_rdata), .dma_req(dma_req),
      .dma_addr(dma_addr), .dma_write(dma_write), .dma_wdata(dma_wdata), .dma_ack(dma_ack),
      .dma_err(dma_err), .dma_rdata(dma_rdata), .bank_select_lines_n(sel_n),
      .mem_addr(mem_addr), .external_port_data_bus_out(bus_out),
      .external_port_data_bus_oe(oe), .external_port_data_bus_in(bus_in), .mem_rd_n(rd_n),
      .mem_wr_n(wr_n), .sdram_cmd(cmd));
   ebp_mem_model u_mem (.pclk(pclk), .bank_select_lines_n(sel_n), .mem_addr(mem_addr),
      .external_port_data_bus_out(bus_out), .external_port_data_bus_oe(oe), .mem_wr_n(wr_n),
      .sdram_cmd(cmd), .external_port_data_bus_in(bus_in));
   // ****
   // tasks
   // ****
   task automatic report_and_stop;
      if (failures == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 50) begin
         failures++;
         report_and_stop();
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r32, e);
      chk("apb_write_err", 64'h0, {63'h0, e});
   endtask
   task automatic mreq(input logic m, input logic [31:0] a, input logic w,
      input logic [63:0] d, input logic [1:0] kind, output logic [63:0] r,
      output logic err, output logic sel, output int t);
      sel = 1'b0;
      @(posedge pclk);
      if (m) begin
         dma_req <= 1'b1;
         dma_addr <= a;
         dma_write <= w;
         dma_wdata <= d;
      end else begin
         core_req <= 1'b1;
         core_addr <= a;
         core_write <= w;
         core_wdata <= d;
         core_simd <= kind[0];
         core_fetch <= kind[1];
      end
      for (t = 0; t < 800; t++) begin
         @(posedge pclk);
         sel |= sel_n != 4'hf;
         if ((m ? dma_ack : core_ack) === 1'b1) break;
      end
      if (t == 800) begin
         failures++;
         report_and_stop();
      end
      r = m ? dma_rdata : core_rdata;
      err = m ? dma_err : core_err;
      if (m) dma_req <= 1'b0;
      else core_req <= 1'b0;
   endtask
   task automatic acc(input logic [31:0] a, input logic w, input logic [63:0] d,
      input logic [1:0] kind, input logic bad, input logic [63:0] mask);
      mreq(1'b0, a, w, d, kind, rd, e, s, tm);
      chk("mem_err", {63'h0, bad}, {63'h0, e});
      chk("mem_select", {63'h0, !bad}, {63'h0, s});
      if (!w && !bad) chk("mem_rdata", d & mask, rd & mask);
   endtask
   // ****
   // main sequence
   // ****
   initial begin
      logic [7:0] offs [5] = '{EBP_REG_BANK_MODE, EBP_REG_ASYNC_TIMING, EBP_REG_SDRAM_SIZE,
         EBP_REG_SDRAM_TIMING, 8'h14};
      logic [31:0] rst [5] = '{EBP_RST_BANK_MODE, EBP_RST_ASYNC_TIMING, EBP_RST_SDRAM_SIZE,
         EBP_RST_SDRAM_TIMING, 32'h0};
      logic [31:0] off [5] = '{32'h0480_0000, 32'h0c80_0000, 32'h001f_ffff, 32'h0080_0000,
         32'h1000_0000};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, offs[i], 32'h0, r32, e);
         chk("reg_reset", {32'h0, rst[i]}, {32'h0, r32});
         chk("reg_err", 64'(i == 4), {63'h0, e});
      end
      wr(EBP_REG_ASYNC_TIMING, 32'h0400_0000);
      acc(32'h0400_0010, 1'b1, 64'ha5a5_0001, 2'b00, 1'b0, 64'h0);
      t1 = tm;
      acc(32'h0c00_0010, 1'b1, 64'h5a5a_0003, 2'b00, 1'b0, 64'h0);
      t2 = tm;
      chk("async_wait_gap", 64'd4, 64'(t2 - t1));
      acc(32'h047f_ffff, 1'b1, 64'h1234_5678, 2'b00, 1'b0, 64'h0);
      acc(32'h0400_0010, 1'b0, 64'ha5a5_0001, 2'b00, 1'b0, 64'hffff_ffff);
      acc(32'h0c00_0010, 1'b0, 64'h5a5a_0003, 2'b00, 1'b0, 64'hffff_ffff);
      acc(32'h047f_ffff, 1'b0, 64'h1234_5678, 2'b00, 1'b0, 64'hffff_ffff);
      for (int i = 0; i < 5; i++) acc(off[i], 1'b0, 64'h0, 2'b00, 1'b1, 64'h0);
      wr(EBP_REG_BANK_MODE, 32'h0000_0005);
      wr(EBP_REG_SDRAM_SIZE, 32'h0000_0006);
      acc(32'h0300_0000, 1'b1, 64'h0123_4567_89ab_cdef, 2'b01, 1'b0, 64'h0);
      acc(32'h0300_0000, 1'b0, 64'h0123_4567_89ab_cdef, 2'b01, 1'b0, '1);
      t1 = tm;
      acc(32'h0800_0100, 1'b1, 64'hcafe_0002, 2'b00, 1'b0, 64'h0);
      acc(32'h0800_0100, 1'b0, 64'hcafe_0002, 2'b00, 1'b0, 64'hffff_ffff);
      acc(32'h0810_0000, 1'b0, 64'h0, 2'b00, 1'b1, 64'h0);
      wr(EBP_REG_SDRAM_TIMING, 32'h0000_1333);
      acc(32'h0300_0000, 1'b0, 64'h0123_4567_89ab_cdef, 2'b01, 1'b0, '1);
      chk("ext_buffer_gap", 64'd1, 64'(tm - t1));
      wr(EBP_REG_SDRAM_TIMING, 32'h0000_0343);
      acc(32'h0300_0000, 1'b0, 64'h0123_4567_89ab_cdef, 2'b01, 1'b0, '1);
      chk("trcd_gap", 64'd1, 64'(tm - t1));
      acc(32'h0020_0000, 1'b1, 64'h1122_3344_5566_7788, 2'b01, 1'b0, 64'h0);
      acc(32'h0020_0000, 1'b0, 64'h1122_3344_5566_7788, 2'b10, 1'b0, 64'hffff_ffff_ffff);
      acc(32'h0060_0000, 1'b0, 64'h0, 2'b10, 1'b1, 64'h0);
      acc(32'h0400_0010, 1'b0, 64'h0, 2'b10, 1'b1, 64'h0);
      acc(32'h0020_0000, 1'b1, 64'h0, 2'b10, 1'b1, 64'h0);
      wr(EBP_REG_BANK_MODE, 32'h0000_0015);
      acc(32'h0060_0000, 1'b1, 64'h99aa_bbcc_ddee_ff00, 2'b01, 1'b0, 64'h0);
      acc(32'h0060_0000, 1'b0, 64'h99aa_bbcc_ddee_ff00, 2'b10, 1'b0, 64'hffff_ffff_ffff);
      acc(32'h0020_0000, 1'b0, 64'h0, 2'b10, 1'b1, 64'h0);
      fork
         mreq(1'b0, 32'h0400_0010, 1'b0, 64'h0, 2'b00, rd, e, s, t1);
         mreq(1'b1, 32'h0c00_0010, 1'b0, 64'h0, 2'b00, rd2, e2, s2, t2);
      join
      chk("core_rdata", 64'ha5a5_0001, {32'h0, rd[31:0]});
      chk("dma_rdata", 64'h5a5a_0003, {32'h0, rd2[31:0]});
      chk("dma_err", 64'h0, {63'h0, e2});
      chk("dma_select", 64'h1, {63'h0, s2});
      chk("dma_first", 64'h1, 64'(t2 < t1));
      apb(1'b0, EBP_REG_STATUS, 32'h0, r32, e);
      chk("status_refused", 64'h000a_0000, {32'h0, r32});
      report_and_stop();
   end
endmodule
